// ===== common/ccrs_pkg.sv
// Purpose: Shared constants and types of the coupler configuration and redundancy supervisor
// Assumes: 20 MHz system clock; switch contacts read as 1 when closed
// Notes:   Register numbers are the station-bus register addresses
package ccrs_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 50;
    localparam int SAMPLE_TIME_NS    = 800;
    localparam int SAMPLE_CYCLES     = (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEBOUNCE_TIME_NS  = 400;
    localparam int DEBOUNCE_CYCLES   = (DEBOUNCE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TWIN_WATCH_MS     = 10;
    localparam int TWIN_WATCH_CYCLES = TWIN_WATCH_MS * 1000000 / CLK_PERIOD_NS;
    localparam int HANDOVER_CYCLES   = 4;

    // ------------------------------------------------------------
    // Register numbers and unit identifiers
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CAUSE_A = 8'hE7;
    localparam logic [7:0] REG_CAUSE_B = 8'hEB;
    localparam logic [7:0] REG_DIAG    = 8'hF6;
    localparam logic [7:0] UNIT_ID_LO  = 8'h3C;
    localparam logic [7:0] UNIT_ID_HI  = 8'h3D;
    localparam logic [7:0] UNIT_ID_AUX = 8'h3E;

    // ------------------------------------------------------------
    // Option switch contacts (bit 0 is contact 1)
    // ------------------------------------------------------------
    localparam int OPT_UNIT   = 0;
    localparam int OPT_KIND   = 1;
    localparam int OPT_SPARE3 = 2;
    localparam int OPT_SLOT   = 3;
    localparam int OPT_SPARE5 = 4;
    localparam int OPT_SPARE6 = 5;
    localparam int OPT_DOM_LO = 6;
    localparam int OPT_DOM_HI = 7;

    // ------------------------------------------------------------
    // Diagnostic word and cause register bits
    // ------------------------------------------------------------
    localparam int DIAG_SUPPLY     = 0;
    localparam int DIAG_HEAT       = 1;
    localparam int DIAG_DOOR       = 2;
    localparam int DIAG_CFG_SINGLE = 7;
    localparam int DIAG_CFG_DUAL   = 11;
    localparam int DIAG_TWIN_FAIL  = 12;
    localparam int CAUSE_SPARE     = 0;
    localparam int CAUSE_UNIT      = 1;
    localparam int CAUSE_NODE      = 2;
    localparam int CAUSE_DOMAIN    = 3;
    localparam int CAUSE_KIND      = 4;
    localparam int CAUSE_SAME_UNIT = 5;
    localparam logic [15:0] REG_RESET = 16'h0000;

    typedef enum logic [2:0] {
        ROLE_INIT    = 3'b001,
        ROLE_PASSIVE = 3'b010,
        ROLE_ACTIVE  = 3'b100
    } ccrs_role_type;

    typedef struct packed {
        logic [7:0] node;
        logic [1:0] domain;
    } ccrs_addr_tlg_type;

    typedef struct packed {
        logic [7:0] node;
        logic [1:0] domain;
        logic       ringKind;
        logic       unitHi;
    } ccrs_twin_cfg_type;
endpackage

// ===== rtl/ccrs_top.sv
// Purpose: Switch decode, alarm supervision and twin redundancy of a ring coupler
// Assumes: Protocol engine pulses stationCycleStart when it issues a start-of-cycle telegram
// Notes:   Registers are read by number over the station-bus register port
//
// How it works
// - Node number from first switch, binary weights
// - Option contacts select unit, kind, slot check
// - Domain identifier from option contacts 7, 8
// - Unit identifier 62 always answered too
// - Broadcast node number and domain telegram
// - Bad setting flags bit 7 or 11
// - Bad setting holds general fault lamp
// - Fault cause readable in cause registers
// - Supply input fails when signal lost
// - Heat, door inputs fail when present
// - Any alarm: diag entry, summary output
// - Spare fault output stays inactive
// - Active hands over every four cycles
// - Cyclic exchange lets passive check active
// - Monitor cuts failed twin's bus drivers
// - Record twin failure; failed lights lamps
// - Controller uses ring 1 or 2
// - Second port: rx ring2 tx ring1; first reverse
// - Address telegram at init, every cycle
// - Cycle runs start telegram to next
`timescale 1ns/1ns
module ccrs_top #(
    parameter int WATCH_CYCLES = ccrs_pkg::TWIN_WATCH_CYCLES
) (
    input  wire logic                        sys_clk,
    input  wire logic                        sys_rst,
    input  wire logic [7:0]                  nodeNumberSwitch,
    input  wire logic [7:0]                  optionSwitch,
    input  wire logic                        stationCycleStart,
    input  wire logic                        supplyLossInput,
    input  wire logic                        heatAlarmInput,
    input  wire logic                        doorAlarmInput,
    input  wire logic                        twinPresent,
    input  wire logic                        twinHandoverIn,
    input  wire logic                        twinExchangeIn,
    input  wire ccrs_pkg::ccrs_twin_cfg_type twinCfgIn,
    input  wire logic                        twinCutIn,
    input  wire logic [7:0]                  regUnit,
    input  wire logic [7:0]                  regNum,
    input  wire logic                        regRead,
    input  wire logic                        ring1Rx,
    input  wire logic                        ring2Rx,
    input  wire logic                        macTxData,
    input  wire logic                        macRingSel,
    output logic                             addrTlgValid,
    output ccrs_pkg::ccrs_addr_tlg_type      addrTlg,
    output logic [7:0]                       unitIdentifier,
    output logic                             standaloneKind,
    output logic                             slotPresenceCheck,
    output logic                             controlActive,
    output logic                             handoverOut,
    output logic                             exchangeOut,
    output ccrs_pkg::ccrs_twin_cfg_type      twinCfgOut,
    output logic                             twinCutOut,
    output logic                             ownDriverEnable,
    output logic                             summaryFaultOutput,
    output logic                             spareFaultOutput,
    output logic                             generalFaultLamp,
    output logic                             unitFaultLamp,
    output logic [15:0]                      regData,
    output logic                             regValid,
    output logic                             ring1Tx,
    output logic                             ring2Tx,
    output logic                             macRxData
);
    // ------------------------------------------------------------
    // Alarm inputs
    // ------------------------------------------------------------
    logic [2:0] alarmRaw;
    logic [2:0] alarmLevel;

    // Raw pins in; polarity is applied after the synchroniser
    assign alarmRaw = {doorAlarmInput, heatAlarmInput, supplyLossInput};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_alarm
            logic       syncA_q, syncB_q, level_q, level_d;
            logic [3:0] stable_q, stable_d;
            logic       disturbed;

            // Supply uses closed circuit, heat and door open circuit
            assign disturbed = (gi == 0) ? ~syncB_q : syncB_q;

            // Level only moves after it has held for the whole debounce window
            always_comb begin
                stable_d = stable_q;
                level_d  = level_q;
                if (disturbed == level_q) begin
                    stable_d = 4'h0;
                end else if (stable_q == 4'(ccrs_pkg::DEBOUNCE_CYCLES - 1)) begin
                    stable_d = 4'h0;
                    level_d  = disturbed;
                end else begin
                    stable_d = stable_q + 4'h1;
                end
            end

            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    // Idle level of each pin, so release shows no false change
                    syncA_q  <= 1'(gi == 0);
                    syncB_q  <= 1'(gi == 0);
                    stable_q <= 4'h0;
                    level_q  <= 1'b0;
                end else begin
                    syncA_q  <= alarmRaw[gi];
                    syncB_q  <= syncA_q;
                    stable_q <= stable_d;
                    level_q  <= level_d;
                end
            end
            assign alarmLevel[gi] = level_q;
        end
    endgenerate

    // ------------------------------------------------------------
    // Switch sampling and configuration check
    // ------------------------------------------------------------
    ccrs_pkg::ccrs_role_type role_q, role_d;
    logic [4:0]  sample_q, sample_d;
    logic [7:0]  node_q, node_d, opt_q, opt_d;
    logic [15:0] causeA;
    logic        cfgBad;
    logic        dualMode;
    logic        latchDone;

    assign latchDone = (role_q == ccrs_pkg::ROLE_INIT)
                     && (sample_q == 5'(ccrs_pkg::SAMPLE_CYCLES - 1));

    // Switches are only read during init so a bumped switch cannot move addresses
    always_comb begin
        sample_d = sample_q;
        node_d   = node_q;
        opt_d    = opt_q;
        if (role_q == ccrs_pkg::ROLE_INIT) begin
            sample_d = sample_q + 5'h01;
            node_d   = nodeNumberSwitch;
            opt_d    = optionSwitch;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sample_q <= 5'h00;
            node_q   <= 8'h00;
            opt_q    <= 8'h00;
        end else begin
            sample_q <= sample_d;
            node_q   <= node_d;
            opt_q    <= opt_d;
        end
    end

    assign dualMode = twinPresent;

    // Cause bits; spare contacts and unit choice are checked against the configurer's duty
    always_comb begin
        causeA = 16'h0000;
        causeA[ccrs_pkg::CAUSE_SPARE] = opt_q[ccrs_pkg::OPT_SPARE3]
            | opt_q[ccrs_pkg::OPT_SPARE5] | opt_q[ccrs_pkg::OPT_SPARE6];
        causeA[ccrs_pkg::CAUSE_UNIT] = ~dualMode & opt_q[ccrs_pkg::OPT_UNIT];
        if (dualMode) begin
            causeA[ccrs_pkg::CAUSE_NODE]   = twinCfgIn.node != node_q;
            causeA[ccrs_pkg::CAUSE_DOMAIN] = twinCfgIn.domain
                != opt_q[ccrs_pkg::OPT_DOM_HI:ccrs_pkg::OPT_DOM_LO];
            causeA[ccrs_pkg::CAUSE_KIND] = twinCfgIn.ringKind != opt_q[ccrs_pkg::OPT_KIND];
            causeA[ccrs_pkg::CAUSE_SAME_UNIT] = twinCfgIn.unitHi == opt_q[ccrs_pkg::OPT_UNIT];
        end
    end
    assign cfgBad = (role_q != ccrs_pkg::ROLE_INIT) && (causeA != 16'h0000);

    // ------------------------------------------------------------
    // Twin role, handover and monitoring
    // ------------------------------------------------------------
    logic [2:0]  cycCnt_q, cycCnt_d;
    logic [23:0] watch_q, watch_d;
    logic        twinFail_q, twinFail_d;
    logic        selfCut_q, selfCut_d;
    logic        handover_d, exchange_d;
    logic        lastCycle;

    assign lastCycle = stationCycleStart
                     && (cycCnt_q == 3'(ccrs_pkg::HANDOVER_CYCLES - 1));

    // Lower unit starts active; a single module or a survivor keeps control
    always_comb begin
        role_d     = role_q;
        cycCnt_d   = cycCnt_q;
        watch_d    = watch_q;
        twinFail_d = twinFail_q;
        selfCut_d  = selfCut_q | twinCutIn;
        handover_d = 1'b0;
        exchange_d = 1'b0;
        case (role_q)
            ccrs_pkg::ROLE_INIT: begin
                if (latchDone) begin
                    role_d = (dualMode && optionSwitch[ccrs_pkg::OPT_UNIT])
                           ? ccrs_pkg::ROLE_PASSIVE : ccrs_pkg::ROLE_ACTIVE;
                end
            end
            ccrs_pkg::ROLE_ACTIVE: begin
                exchange_d = stationCycleStart & ~selfCut_q;
                if (selfCut_d) begin
                    role_d = ccrs_pkg::ROLE_PASSIVE;
                end else if (stationCycleStart && dualMode && !twinFail_q) begin
                    cycCnt_d = cycCnt_q + 3'h1;
                    if (lastCycle) begin
                        cycCnt_d   = 3'h0;
                        handover_d = 1'b1;
                        role_d     = ccrs_pkg::ROLE_PASSIVE;
                    end
                end
            end
            ccrs_pkg::ROLE_PASSIVE: begin
                watch_d = (twinExchangeIn || twinHandoverIn) ? 24'h000000
                        : watch_q + 24'h000001;
                if (!dualMode && !selfCut_q) begin
                    role_d = ccrs_pkg::ROLE_ACTIVE;
                end else if (twinHandoverIn && !selfCut_d) begin
                    role_d  = ccrs_pkg::ROLE_ACTIVE;
                    watch_d = 24'h000000;
                end else if (watch_q == 24'(WATCH_CYCLES - 1) && !selfCut_d) begin
                    twinFail_d = 1'b1;
                    role_d     = ccrs_pkg::ROLE_ACTIVE;
                    watch_d    = 24'h000000;
                end
            end
            default: role_d = ccrs_pkg::ROLE_INIT;
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            role_q     <= ccrs_pkg::ROLE_INIT;
            cycCnt_q   <= 3'h0;
            watch_q    <= 24'h000000;
            twinFail_q <= 1'b0;
            selfCut_q  <= 1'b0;
        end else begin
            role_q     <= role_d;
            cycCnt_q   <= cycCnt_d;
            watch_q    <= watch_d;
            twinFail_q <= twinFail_d;
            selfCut_q  <= selfCut_d;
        end
    end

    // ------------------------------------------------------------
    // Diagnostic word and register read port
    // ------------------------------------------------------------
    logic [15:0] diagWord;
    logic [15:0] readData;
    logic        unitMatch;

    always_comb begin
        diagWord = 16'h0000;
        diagWord[ccrs_pkg::DIAG_SUPPLY]     = alarmLevel[0];
        diagWord[ccrs_pkg::DIAG_HEAT]       = alarmLevel[1];
        diagWord[ccrs_pkg::DIAG_DOOR]       = alarmLevel[2];
        diagWord[ccrs_pkg::DIAG_CFG_SINGLE] = cfgBad & ~dualMode;
        diagWord[ccrs_pkg::DIAG_CFG_DUAL]   = cfgBad & dualMode;
        diagWord[ccrs_pkg::DIAG_TWIN_FAIL]  = twinFail_q;
    end

    // Answers on its own switched unit and on the fixed auxiliary unit
    assign unitMatch = (regUnit == ccrs_pkg::UNIT_ID_AUX) || (regUnit == unitIdentifier);

    always_comb begin
        readData = 16'h0000;
        case (regNum)
            ccrs_pkg::REG_CAUSE_A: readData = causeA;
            ccrs_pkg::REG_CAUSE_B: readData = {node_q, opt_q};
            ccrs_pkg::REG_DIAG:    readData = diagWord;
            default:               readData = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    logic tlgSend;
    logic driverOn;

    assign tlgSend  = (latchDone || (stationCycleStart && role_q != ccrs_pkg::ROLE_INIT));
    assign driverOn = ~selfCut_d && (role_d != ccrs_pkg::ROLE_INIT);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            addrTlgValid       <= 1'b0;
            addrTlg            <= '0;
            unitIdentifier     <= ccrs_pkg::UNIT_ID_LO;
            standaloneKind     <= 1'b0;
            slotPresenceCheck  <= 1'b0;
            controlActive      <= 1'b0;
            handoverOut        <= 1'b0;
            exchangeOut        <= 1'b0;
            twinCfgOut         <= '0;
            twinCutOut         <= 1'b0;
            ownDriverEnable    <= 1'b0;
            summaryFaultOutput <= 1'b0;
            spareFaultOutput   <= 1'b0;
            generalFaultLamp   <= 1'b0;
            unitFaultLamp      <= 1'b0;
            regData            <= ccrs_pkg::REG_RESET;
            regValid           <= 1'b0;
            ring1Tx            <= 1'b0;
            ring2Tx            <= 1'b0;
            macRxData          <= 1'b0;
        end else begin
            addrTlgValid   <= tlgSend;
            addrTlg.node   <= node_d;
            addrTlg.domain <= opt_d[ccrs_pkg::OPT_DOM_HI:ccrs_pkg::OPT_DOM_LO];
            unitIdentifier <= opt_d[ccrs_pkg::OPT_UNIT] ? ccrs_pkg::UNIT_ID_HI
                                                        : ccrs_pkg::UNIT_ID_LO;
            standaloneKind    <= ~opt_d[ccrs_pkg::OPT_KIND];
            slotPresenceCheck <= opt_d[ccrs_pkg::OPT_SLOT];
            controlActive     <= (role_d == ccrs_pkg::ROLE_ACTIVE) & ~selfCut_d;
            handoverOut       <= handover_d;
            exchangeOut       <= exchange_d;
            twinCfgOut        <= {node_d, opt_d[ccrs_pkg::OPT_DOM_HI:ccrs_pkg::OPT_DOM_LO],
                                  opt_d[ccrs_pkg::OPT_KIND], opt_d[ccrs_pkg::OPT_UNIT]};
            twinCutOut        <= twinFail_d;
            ownDriverEnable   <= driverOn;
            summaryFaultOutput <= |alarmLevel;
            spareFaultOutput  <= 1'b0;
            generalFaultLamp  <= cfgBad | selfCut_d;
            unitFaultLamp     <= selfCut_d;
            regValid          <= regRead & unitMatch;
            regData           <= (regRead & unitMatch) ? readData : 16'h0000;
            // Ring 1 leaves by the second port, ring 2 by the first
            ring1Tx   <= driverOn & ~macRingSel & macTxData;
            ring2Tx   <= driverOn & macRingSel & macTxData;
            macRxData <= macRingSel ? ring2Rx : ring1Rx;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_fourth_cycle;
        role_q == ccrs_pkg::ROLE_ACTIVE && !selfCut_d && dualMode && !twinFail_q && lastCycle;
    endsequence

    property p_handover;
        @(posedge sys_clk) disable iff (sys_rst)
        s_fourth_cycle |=> handoverOut && !controlActive;
    endproperty
    a_handover: assert property (p_handover) else $error("missed handover");

    property p_spare;
        @(posedge sys_clk) disable iff (sys_rst) !spareFaultOutput;
    endproperty
    a_spare: assert property (p_spare) else $error("spare output active");

    property p_summary;
        @(posedge sys_clk) disable iff (sys_rst)
        ##1 summaryFaultOutput == (|$past(alarmLevel));
    endproperty
    a_summary: assert property (p_summary) else $error("summary mismatch");

    property p_cfg_lamp;
        @(posedge sys_clk) disable iff (sys_rst) cfgBad |=> generalFaultLamp;
    endproperty
    a_cfg_lamp: assert property (p_cfg_lamp) else $error("lamp not lit");

    property p_cfg_bit;
        @(posedge sys_clk) disable iff (sys_rst)
        (cfgBad && !dualMode) |-> diagWord[7] && !diagWord[11];
    endproperty
    a_cfg_bit: assert property (p_cfg_bit) else $error("wrong config bit");

    property p_cut;
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(twinFail_q) |-> twinCutOut && diagWord[12];
    endproperty
    a_cut: assert property (p_cut) else $error("twin not cut");

    property p_self_fail;
        @(posedge sys_clk) disable iff (sys_rst)
        twinCutIn |=> !ownDriverEnable && unitFaultLamp && generalFaultLamp;
    endproperty
    a_self_fail: assert property (p_self_fail) else $error("failed unit lamps");

    property p_tlg_init;
        @(posedge sys_clk) disable iff (sys_rst)
        latchDone |=> addrTlgValid && addrTlg.node == $past(nodeNumberSwitch);
    endproperty
    a_tlg_init: assert property (p_tlg_init) else $error("no init telegram");

    property p_hold;
        @(posedge sys_clk) disable iff (sys_rst)
        role_q != ccrs_pkg::ROLE_INIT |=> $stable(node_q) && $stable(opt_q);
    endproperty
    a_hold: assert property (p_hold) else $error("switch value moved");
endmodule

// ===== test/ccrs_top_bench.sv
// Purpose: Self-checking bench of the coupler supervisor
// Assumes: Inputs driven on the falling edge, replies checked from a queue
// Notes:   Watchdog shortened to 50 cycles so twin loss shows quickly
`timescale 1ns/1ns
module ccrs_top_bench;
    logic        sys_clk = 1'h0;
    logic        sys_rst = 1'h1;
    logic [7:0]  node, opt, regUnit, regNum, lfsrQ;
    logic        cycStart, supplyOk, heat, door, twinOn, mute, regRead;
    logic        ring1Rx, ring2Rx, macTx, macSel, twinHo, twinEx, hoSeen;
    logic        tlgV, ctrlOn, hoOut, cutOut, drvEn, sumF, spareF, genLamp;
    logic        regValid, ring1Tx, ring2Tx, macRx, aloneK, slotK, exOut, cutIn, unitLamp;
    logic [15:0] regData;
    logic [7:0]  unitId;
    ccrs_pkg::ccrs_addr_tlg_type addrTlg;
    ccrs_pkg::ccrs_twin_cfg_type twinCfg, cfgOut;
    logic [15:0] expQ[$];
    int          n_fail, comparisons, i, k, r;
    assign twinCfg = {node, opt[7:6], opt[1], 1'h1};
    ccrs_top #(.WATCH_CYCLES(50)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .nodeNumberSwitch(node), .optionSwitch(opt), .stationCycleStart(cycStart),
        .supplyLossInput(supplyOk), .heatAlarmInput(heat), .doorAlarmInput(door),
        .twinPresent(twinOn), .twinHandoverIn(twinHo), .twinExchangeIn(twinEx),
        .twinCfgIn(twinCfg), .twinCutIn(cutIn), .regUnit(regUnit), .regNum(regNum),
        .regRead(regRead), .ring1Rx(ring1Rx), .ring2Rx(ring2Rx), .macTxData(macTx),
        .macRingSel(macSel), .addrTlgValid(tlgV), .addrTlg(addrTlg),
        .unitIdentifier(unitId), .standaloneKind(aloneK), .slotPresenceCheck(slotK),
        .controlActive(ctrlOn), .handoverOut(hoOut), .exchangeOut(exOut), .twinCfgOut(cfgOut),
        .twinCutOut(cutOut), .ownDriverEnable(drvEn), .summaryFaultOutput(sumF),
        .spareFaultOutput(spareF), .generalFaultLamp(genLamp), .unitFaultLamp(unitLamp),
        .regData(regData), .regValid(regValid), .ring1Tx(ring1Tx), .ring2Tx(ring2Tx),
        .macRxData(macRx));
    ccrs_twin_model twin (.sys_clk(sys_clk), .sys_rst(sys_rst), .cycStart(cycStart),
        .takeCtrl(hoOut), .mute(mute), .giveCtrl(twinHo), .exchange(twinEx));
    initial forever #25 sys_clk = ~sys_clk;
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        n_fail += expQ.size();
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Reset, sample switches, wait for the first address telegram
    task automatic boot(input logic [7:0] o, input logic dual);
        sys_rst = 1'h1;
        lfsrQ = lfsr(lfsrQ);
        node = lfsrQ;
        opt = o;
        twinOn = dual;
        repeat (6) @(negedge sys_clk);
        sys_rst = 1'h0;
        for (i = 0; i < 40 && tlgV !== 1'h1; i++) @(negedge sys_clk);
        if (i == 40) begin
            n_fail++;
            $display("unexpected at %0t: no address telegram", $time);
            wrap_up();
        end
    endtask
    // Register read; a refused unit leaves no note in the queue
    task automatic rd(input logic [7:0] u, input logic [7:0] n, input logic [15:0] e,
                      input logic ans);
        regUnit = u;
        regNum = n;
        regRead = 1'h1;
        @(negedge sys_clk);
        regRead = 1'h0;
        if (ans) expQ.push_back(e);
        repeat (3) @(negedge sys_clk);
    endtask
    // One start pulse; the one-cycle replies stand only until the next edge
    task automatic cyc(input logic single);
        cycStart = 1'h1;
        @(negedge sys_clk);
        cycStart = 1'h0;
        hoSeen = hoSeen | hoOut;
        if (single) chk({tlgV, exOut}, 2'h3);
        repeat (5) @(negedge sys_clk);
    endtask
    // Replies are matched against the oldest note
    always @(posedge sys_clk) begin
        if (regValid === 1'h1) begin
            if (expQ.size() == 0) chk(regData, 16'hDEAD);
            else chk(regData, expQ.pop_front());
        end
    end
    initial begin
        #3ms;
        n_fail++;
        $display("unexpected at %0t: run limit reached", $time);
        wrap_up();
    end
    initial begin
        {cycStart, heat, door, mute, regRead, macTx, macSel, ring2Rx, cutIn} = '0;
        {supplyOk, ring1Rx} = 2'h3;
        {regUnit, regNum, hoSeen} = '0;
        lfsrQ = 8'h2F;
        boot(8'h88, 1'h0);
        chk(addrTlg, {node, 2'h2});
        chk({unitId, aloneK, slotK}, {8'h3C, 2'h3});
        rd(8'h3E, ccrs_pkg::REG_DIAG, 16'h0000, 1'h1);
        rd(8'h3C, ccrs_pkg::REG_CAUSE_B, {node, opt}, 1'h1);
        rd(8'h3D, ccrs_pkg::REG_DIAG, 16'h0000, 1'h0);
        rd(8'h3C, 8'h10, 16'h0000, 1'h1);
        cyc(1'h1);
        $display("done: switches and registers");
        for (k = 0; k < 2; k++) begin
            macSel = k[0];
            macTx = 1'h1;
            repeat (2) @(negedge sys_clk);
            chk({ring1Tx, ring2Tx, macRx}, {!k[0], k[0], !k[0]});
        end
        $display("done: ring routing");
        for (k = 0; k < 3; k++) begin
            {supplyOk, heat, door} = {k != 0, k == 1, k == 2};
            repeat (14) @(negedge sys_clk);
            chk({sumF, spareF}, 2'h2);
            rd(8'h3E, ccrs_pkg::REG_DIAG, 16'h1 << k, 1'h1);
            {supplyOk, heat, door} = 3'h4;
            repeat (14) @(negedge sys_clk);
            chk(sumF, 1'h0);
        end
        door = 1'h1;
        repeat (4) @(negedge sys_clk);
        door = 1'h0;
        repeat (14) @(negedge sys_clk);
        chk(sumF, 1'h0);
        $display("done: alarms");
        boot(8'h8C, 1'h0);
        @(negedge sys_clk);
        chk(genLamp, 1'h1);
        rd(8'h3E, ccrs_pkg::REG_DIAG, 16'h0080, 1'h1);
        rd(8'h3E, ccrs_pkg::REG_CAUSE_A, 16'h0001, 1'h1);
        $display("done: illegal setting");
        boot(8'h88, 1'h1);
        chk({ctrlOn, drvEn}, 2'h3);
        chk(cfgOut, {node, 4'h8});
        for (r = 0; r < 3; r++) begin
            hoSeen = 1'h0;
            repeat (4) cyc(1'h0);
            chk({hoSeen, ctrlOn}, {r != 1, r == 1});
        end
        mute = 1'h1;
        repeat (12) cyc(1'h0);
        chk({cutOut, ctrlOn}, 2'h3);
        rd(8'h3E, ccrs_pkg::REG_DIAG, 16'h1000, 1'h1);
        cutIn = 1'h1;
        @(negedge sys_clk);
        chk({drvEn, ctrlOn, genLamp, unitLamp, ring2Tx}, 5'h06);
        $display("done: twin redundancy");
        wrap_up();
    end
endmodule

// ===== test/ccrs_twin_model.sv
// Purpose: Twin coupler stand-in for dual-channel runs
// Assumes: One start pulse per station cycle
// Notes:   mute makes the twin fall silent while it holds control
`timescale 1ns/1ns
module ccrs_twin_model (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic cycStart,
    input  wire logic takeCtrl,
    input  wire logic mute,
    output logic      giveCtrl,
    output logic      exchange
);
    logic       active_q;
    logic [1:0] count_q;
    logic       serve;
    assign serve = active_q && cycStart && !mute;
    // Serve four cycles once handed control, then hand back
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            active_q <= 1'h0;
            count_q  <= 2'h0;
            giveCtrl <= 1'h0;
            exchange <= 1'h0;
        end else begin
            giveCtrl <= serve && count_q == 2'h3;
            exchange <= serve;
            if (takeCtrl) begin
                active_q <= 1'h1;
                count_q  <= 2'h0;
            end else if (serve) begin
                active_q <= count_q != 2'h3;
                count_q  <= count_q + 2'h1;
            end
        end
    end
endmodule
